// [dv/iatrap_cpu_model.sv]
// Stand-in for the CPU core: prefetch address, state and completion strobes.
// Assumes the bench calls drive once for every clock it wants to shape.
`timescale 1ns/1ps
module iatrap_cpu_model (
	input wire logic clk_sys,
	output logic [23:0] cpu_addr,
	output logic cpu_prefetch,
	output logic cpu_state_en,
	output logic cpu_insn_done
);
	// ----------------------------------------
	// Strobes
	// ----------------------------------------
	initial begin
		cpu_addr = 24'h0;
		cpu_prefetch = 1'b0;
		cpu_state_en = 1'b0;
		cpu_insn_done = 1'b0;
	end
	// Outside a prefetch the bus shows the inverse of the last value, so a stale match fails.
	task automatic drive(input logic [23:0] a, input logic pf, input logic st, input logic dn);
		@(posedge clk_sys);
		cpu_addr <= pf ? a : ~cpu_addr;
		cpu_prefetch <= pf;
		cpu_state_en <= st;
		cpu_insn_done <= dn;
	endtask
endmodule // iatrap_cpu_model

// [dv/iatrap_unit_assertions.sv]
// Port checker for the instruction address trap unit.
// Assumes it is bound onto iatrap_unit and sees only its ports.
`timescale 1ns/1ps
module iatrap_unit_checker
	import iatrap_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_state_en,
	input wire logic cpu_insn_done,
	input wire logic trap_irq,
	input wire logic trap_take,
	input wire logic irq
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire logic rd_ok = pready && !pwrite && !pslverr;
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_err_align: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("misaligned access not refused");
	a_ctrl_ones: assert property (rd_ok && paddr[17:2] == TRAP_CONTROL_IDX |->
		prdata[7:3] == 5'h1F)
		else $error("control upper bits not one");
	a_low_even: assert property (rd_ok &&
		paddr[17:2] inside {16'hFFB2, 16'hFFB5, 16'hFFB8} |-> !prdata[0])
		else $error("low byte bit zero set");
	a_irq_rise: assert property ($rose(trap_irq) |-> $past(cpu_state_en))
		else $error("trap request rose outside a state");
	a_irq_hold: assert property (trap_irq && !cpu_insn_done |=> trap_irq)
		else $error("trap request dropped early");
	a_take_cause: assert property (trap_take |->
		$past(trap_irq && cpu_insn_done) && !trap_irq)
		else $error("handling start without cause");
	a_take_pulse: assert property (trap_take |=> !trap_take)
		else $error("handling start longer than one cycle");
	c_trap: cover property (trap_take);
	c_irq: cover property ($rose(irq));
	c_err: cover property (pready && pslverr);
endmodule // iatrap_unit_checker

bind iatrap_unit iatrap_unit_checker i_chk (.clk_sys(clk_sys), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cpu_state_en(cpu_state_en), .cpu_insn_done(cpu_insn_done),
	.trap_irq(trap_irq), .trap_take(trap_take), .irq(irq));

// [dv/iatrap_unit_tb_top.sv]
// Self-checking bench for the trap unit: registers, traps and interrupt.
// Assumes the shared package and the CPU stand-in model.
`timescale 1ns/1ps
module iatrap_unit_tb_top;
	import iatrap_pkg::*;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] prdata, rd;
	logic pready, pslverr, trap_irq, trap_take, irq, err;
	logic cpu_prefetch, cpu_state_en, cpu_insn_done;
	logic [23:0] cpu_addr;
	logic [23:0] ta [3];
	logic [23:0] rnd_addr;
	int fail_count = 0;
	int comparisons = 0;
	always #12.5 clk_sys = ~clk_sys;
	iatrap_unit i_iatrap_unit (
		.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_addr(cpu_addr), .cpu_prefetch(cpu_prefetch),
		.cpu_state_en(cpu_state_en), .cpu_insn_done(cpu_insn_done), .trap_irq(trap_irq),
		.trap_take(trap_take), .irq(irq)
	);
	iatrap_cpu_model i_iatrap_cpu_model (
		.clk_sys(clk_sys), .cpu_addr(cpu_addr), .cpu_prefetch(cpu_prefetch),
		.cpu_state_en(cpu_state_en), .cpu_insn_done(cpu_insn_done)
	);
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [31:0] ra(input logic [15:0] idx);
		return {14'h0, idx, 2'b00};
	endfunction
	// A prefetch matches when address bits 23 to 1 agree; bit 0 never counts.
	function automatic logic exp_hit(input logic [23:0] a, input logic [23:0] t);
		return a[23:1] == t[23:1];
	endfunction
	function automatic logic [7:0] bsel(input logic [23:0] a, input int s);
		return s == 0 ? a[23:16] : s == 1 ? a[15:8] : {a[7:1], 1'b0};
	endfunction
	task automatic rdchk(input string nm, input logic [15:0] idx, input logic [7:0] e);
		apb(1'b0, ra(idx), 8'h0);
		chk(nm, {24'h0, e}, rd);
	endtask
	task automatic trap(input logic [23:0] a, input logic hit);
		i_iatrap_cpu_model.drive(a, 1'b1, 1'b1, 1'b0);
		i_iatrap_cpu_model.drive(24'h0, 1'b0, 1'b1, 1'b0);
		i_iatrap_cpu_model.drive(24'h0, 1'b0, 1'b1, 1'b0);
		#1 chk("trap early", 32'h0, {31'h0, trap_irq});
		i_iatrap_cpu_model.drive(24'h0, 1'b0, 1'b0, 1'b1);
		#1 chk("trap_irq", {31'h0, hit}, {31'h0, trap_irq});
		i_iatrap_cpu_model.drive(24'h0, 1'b0, 1'b0, 1'b0);
		#1 chk("trap_take", {31'h0, hit}, {31'h0, trap_take});
		chk("trap_irq fall", 32'h0, {31'h0, trap_irq});
		i_iatrap_cpu_model.drive(24'h0, 1'b0, 1'b0, 1'b0);
	endtask
	task automatic results();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		results();
	end
	initial begin
		void'($urandom(37847));
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		rdchk("ctrl reset", TRAP_CONTROL_IDX, CONTROL_RESERVED_ONES);
		apb(1'b1, ra(TRAP_CONTROL_IDX), 8'h07);
		rdchk("ctrl set", TRAP_CONTROL_IDX, 8'hFF);
		pstrb <= 4'hE;
		apb(1'b1, ra(TRAP_CONTROL_IDX), 8'h00);
		pstrb <= 4'hF;
		rdchk("ctrl strobe", TRAP_CONTROL_IDX, 8'hFF);
		apb(1'b1, ra(TRAP_CONTROL_IDX), 8'h00);
		apb(1'b0, ra(16'hFFBC), 8'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, ra(TRAP_MASK_IDX) | 32'h1, 8'hFF);
		chk("misaligned", 32'h1, {31'h0, err});
		ta[0] = 24'hFFFFFF;
		ta[1] = 24'h000000;
		ta[2] = 24'($urandom());
		for (int r = 0; r < 9; r++) begin
			rdchk("addr reset", 16'hFFB0 + 16'(r), bsel(TRAP_ADDRESS_RESET, r % 3));
			apb(1'b1, ra(16'hFFB0 + 16'(r)), 8'(ta[r / 3] >> (16 - 8 * (r % 3))));
			rdchk("addr", 16'hFFB0 + 16'(r), bsel(ta[r / 3], r % 3));
		end
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, ra(TRAP_CONTROL_IDX), 8'(1 << c));
			trap(ta[c], 1'b0);
			trap(ta[(c + 1) % 3], 1'b0);
			trap(ta[c] | 24'h1, 1'b1);
			rdchk("status", TRAP_STATUS_IDX, 8'(1 << c));
			chk("irq masked", 32'h0, {31'h0, irq});
			apb(1'b1, ra(TRAP_MASK_IDX), 8'(1 << c));
			@(posedge clk_sys);
			#1 chk("irq", 32'h1, {31'h0, irq});
			apb(1'b1, ra(TRAP_STATUS_IDX), 8'(1 << c));
			@(posedge clk_sys);
			#1 chk("irq clear", 32'h0, {31'h0, irq});
			apb(1'b1, ra(TRAP_MASK_IDX), 8'h00);
		end
		for (int r = 0; r < 9; r++) begin
			apb(1'b1, ra(16'hFFB0 + 16'(r)), 8'(ta[2] >> (16 - 8 * (r % 3))));
		end
		apb(1'b1, ra(TRAP_CONTROL_IDX), 8'h07);
		trap(~ta[2], 1'b0);
		trap(ta[2], 1'b1);
		rdchk("status all", TRAP_STATUS_IDX, 8'h07);
		// Half the draws sit on the trap word (either byte), the rest anywhere.
		for (int k = 0; k < 8; k++) begin
			rnd_addr = ($urandom() % 2 == 0) ? (ta[2] ^ 24'($urandom() % 2)) : 24'($urandom());
			trap(rnd_addr, exp_hit(rnd_addr, ta[2]));
		end
		results();
	end
endmodule // iatrap_unit_tb_top

// [hw/iatrap_channel.sv]
// One trap channel: compares its stored even address with the prefetch address.
// Assumes the address and prefetch strobe come from logic on the same clock.
`timescale 1ns/1ps
module iatrap_channel
	import iatrap_pkg::*;
#(
	parameter int unsigned AW = ADDR_WIDTH
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [AW-1:1] trap_addr,
	input wire logic active,
	input wire logic fetch_now,
	input wire logic [AW-1:0] cpu_addr,
	output logic hit
);

	// Bit 0 of the address bus never takes part, so any odd byte of an
	// instruction word would also match; software places traps on even starts.
	always_comb begin
		hit = active && fetch_now && (cpu_addr[AW-1:1] == trap_addr);
	end

endmodule // iatrap_channel

// [hw/iatrap_unit.sv]
// Instruction address trap unit with an APB register slave.
// Assumes the CPU core drives address, prefetch, state and completion strobes on clk_sys.
`timescale 1ns/1ps
// Overview of operation
// - Three independent channels, each with its own address and enable.
// - Control bits 7 to 3 ignore writes and read as one.
// - Control bits 2, 1, 0 enable channels 2, 1, 0; reset disables all.
// - Each address sits in high, middle and low byte registers.
// - Low byte bit 0 is fixed at zero, so addresses are even.
// - Enabled channel matching bus bits 23 to 1 raises a trap request.
// - Comparison covers the whole even 24-bit address range.
// - Trap request rises two CPU states after the matching prefetch.
// - Handling starts when the instruction running in that state completes.
// - A newly set enable starts matching after one more instruction.
// - Taken short branch: trap after the branch target instruction runs.
// - Not-taken short branch: trap after trapped instruction and next prefetch.
// - Not-taken long branch: trap after one or two instructions by length.
// - Trap at untaken branch target: after next instruction, or two if short.
// - After subroutine branch or indirect jumps: trap after target prefetch.
// - After return: trap once stack restored and return target prefetched.
// - After a branch the timing and stacked address depend on the outcome.
module iatrap_unit
	import iatrap_pkg::*;
#(
	parameter int unsigned NUM_CH = 3,
	parameter int unsigned DELAY_STATES = TRAP_DELAY_STATES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ADDR_WIDTH-1:0] cpu_addr,
	input wire logic cpu_prefetch,
	input wire logic cpu_state_en,
	input wire logic cpu_insn_done,
	output logic trap_irq,
	output logic trap_take,
	output logic irq
);

	// ---------------------------------------------------------------
	// Elaboration checks.
	// ---------------------------------------------------------------
	if (NUM_CH != 3) begin : g_bad_ch
		$error("iatrap_unit: the register map holds exactly three channels");
	end
	if (DELAY_STATES < 1 || DELAY_STATES > 7) begin : g_bad_delay
		$error("iatrap_unit: delay must be between 1 and 7 states");
	end

	// ---------------------------------------------------------------
	// Register state.
	// ---------------------------------------------------------------
	localparam logic [2:0] DELAY_LAST = 3'(DELAY_STATES - 1);
	localparam logic [2:0] COUNT_ONE = 3'h1;

	logic [ADDR_WIDTH-1:1] tar_q [NUM_CH];
	logic [NUM_CH-1:0] enable_q;
	logic [NUM_CH-1:0] armed_q;
	logic [NUM_CH-1:0] status_q;
	logic [NUM_CH-1:0] mask_q;
	logic [NUM_CH-1:0] hit;
	logic [NUM_CH-1:0] active;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pslverr_q;
	logic pslverr_d;
	logic trap_irq_q;
	logic trap_take_q;
	logic irq_q;
	logic [2:0] count_q;
	iatrap_state_t state_q;

	logic [15:0] word_idx;
	logic access;
	logic commit;
	logic wr_commit;
	logic byte_wr;
	logic fetch_now;
	logic any_hit;

	assign word_idx = paddr[IDX_MSB:IDX_LSB];
	assign access = psel && penable;
	// The slave answers one cycle into the access phase; data moves only here.
	assign commit = access && pready_q;
	assign wr_commit = commit && pwrite && !pslverr_q;
	assign byte_wr = wr_commit && pstrb[0];
	assign fetch_now = cpu_prefetch && cpu_state_en;
	assign any_hit = |hit;

	// ---------------------------------------------------------------
	// Trap channels.
	// ---------------------------------------------------------------
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
		localparam logic [15:0] BASE = 16'(TRAP_ADDRESS_0_IDX + ch * REGS_PER_CHANNEL);
		localparam logic [15:0] HI_IDX = 16'(BASE + HIGH_BYTE_SEL);
		localparam logic [15:0] MID_IDX = 16'(BASE + MID_BYTE_SEL);
		localparam logic [15:0] LO_IDX = 16'(BASE + LOW_BYTE_SEL);

		// Each channel is written through its own three byte windows.
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				tar_q[ch] <= TRAP_ADDRESS_RESET[ADDR_WIDTH-1:1];
			end else if (byte_wr) begin
				if (word_idx == HI_IDX) begin
					tar_q[ch][23:16] <= pwdata[7:0];
				end
				if (word_idx == MID_IDX) begin
					tar_q[ch][15:8] <= pwdata[7:0];
				end
				if (word_idx == LO_IDX) begin
					tar_q[ch][7:1] <= pwdata[7:1];
				end
			end
		end

		// A fresh enable waits for one completed instruction before it arms,
		// so the instruction that wrote the enable can never trap itself.
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				enable_q[ch] <= 1'b0;
				armed_q[ch] <= 1'b0;
			end else if (byte_wr && word_idx == TRAP_CONTROL_IDX) begin
				enable_q[ch] <= pwdata[ch];
				if (pwdata[ch] && !enable_q[ch]) begin
					armed_q[ch] <= 1'b0;
				end else if (!pwdata[ch]) begin
					armed_q[ch] <= 1'b0;
				end else if (cpu_insn_done) begin
					armed_q[ch] <= 1'b1;
				end
			end else if (cpu_insn_done && enable_q[ch]) begin
				armed_q[ch] <= 1'b1;
			end
		end

		assign active[ch] = enable_q[ch] && armed_q[ch];

		iatrap_channel #(
			.AW(ADDR_WIDTH)
		) u_channel (
			.clk_sys(clk_sys),
			.reset(reset),
			.trap_addr(tar_q[ch]),
			.active(active[ch]),
			.fetch_now(fetch_now),
			.cpu_addr(cpu_addr),
			.hit(hit[ch])
		);

		// Hardware sets win over a write-one-to-clear in the same cycle.
		always_ff @(posedge clk_sys) begin
			if (reset) begin
				status_q[ch] <= 1'b0;
			end else if (hit[ch]) begin
				status_q[ch] <= 1'b1;
			end else if (byte_wr && word_idx == TRAP_STATUS_IDX && pwdata[ch]) begin
				status_q[ch] <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Interrupt mask and level output.
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			mask_q <= MASK_RESET[NUM_CH-1:0];
		end else if (byte_wr && word_idx == TRAP_MASK_IDX) begin
			mask_q <= pwdata[NUM_CH-1:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

	// ---------------------------------------------------------------
	// Trap sequencer toward the CPU exception logic.
	// ---------------------------------------------------------------
	// Branch, return and jump cases need no special path here: they differ only
	// in which addresses the core prefetches and when instructions complete.
	// A match counts even if the core later discards that prefetch, so the
	// trap can land after a branch target and stack that target.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= IATRAP_IDLE;
			count_q <= '0;
			trap_irq_q <= 1'b0;
			trap_take_q <= 1'b0;
		end else begin
			trap_take_q <= 1'b0;
			case (state_q)
				IATRAP_IDLE: begin
					if (any_hit) begin
						state_q <= IATRAP_COUNT;
						count_q <= '0;
					end
				end
				IATRAP_COUNT: begin
					if (cpu_state_en) begin
						if (count_q == DELAY_LAST) begin
							state_q <= IATRAP_RAISED;
							trap_irq_q <= 1'b1;
						end else begin
							count_q <= count_q + COUNT_ONE;
						end
					end
				end
				IATRAP_RAISED: begin
					// Completion seen in the raising cycle does not count, so a
					// one-state instruction there pushes the trap one further.
					if (cpu_insn_done) begin
						state_q <= IATRAP_IDLE;
						trap_irq_q <= 1'b0;
						trap_take_q <= 1'b1;
					end
				end
				default: begin
					state_q <= IATRAP_IDLE;
					trap_irq_q <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// APB slave: one wait state, error on unmapped words.
	// ---------------------------------------------------------------
	always_comb begin
		prdata_d = '0;
		pslverr_d = 1'b1;
		for (int ch = 0; ch < NUM_CH; ch++) begin
			if (word_idx == 16'(TRAP_ADDRESS_0_IDX + ch * REGS_PER_CHANNEL + HIGH_BYTE_SEL)) begin
				prdata_d[7:0] = tar_q[ch][23:16];
				pslverr_d = 1'b0;
			end
			if (word_idx == 16'(TRAP_ADDRESS_0_IDX + ch * REGS_PER_CHANNEL + MID_BYTE_SEL)) begin
				prdata_d[7:0] = tar_q[ch][15:8];
				pslverr_d = 1'b0;
			end
			if (word_idx == 16'(TRAP_ADDRESS_0_IDX + ch * REGS_PER_CHANNEL + LOW_BYTE_SEL)) begin
				prdata_d[7:0] = {tar_q[ch][7:1], 1'b0};
				pslverr_d = 1'b0;
			end
		end
		if (word_idx == TRAP_CONTROL_IDX) begin
			prdata_d[7:0] = CONTROL_RESERVED_ONES | {5'h00, enable_q};
			pslverr_d = 1'b0;
		end
		if (word_idx == TRAP_STATUS_IDX) begin
			prdata_d[7:0] = {5'h00, status_q};
			pslverr_d = 1'b0;
		end
		if (word_idx == TRAP_MASK_IDX) begin
			prdata_d[7:0] = {5'h00, mask_q};
			pslverr_d = 1'b0;
		end
		if (paddr[IDX_LSB-1:0] != 2'h0 || paddr[31:IDX_MSB+1] != '0) begin
			prdata_d = '0;
			pslverr_d = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else if (access && !pready_q) begin
			pready_q <= 1'b1;
			pslverr_q <= pslverr_d;
			prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
		end else begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign trap_irq = trap_irq_q;
	assign trap_take = trap_take_q;
	assign irq = irq_q;

endmodule // iatrap_unit

// [shared/iatrap_pkg.sv]
// Constants shared by the instruction address trap unit and its bench.
// Assumes a 32-bit APB slave with one byte register per aligned word.
package iatrap_pkg;

	// ---------------------------------------------------------------
	// Register indices; byte address is four times the index.
	// ---------------------------------------------------------------
	localparam logic [15:0] TRAP_ADDRESS_0_IDX = 16'hFFB0;
	localparam logic [15:0] TRAP_ADDRESS_1_IDX = 16'hFFB3;
	localparam logic [15:0] TRAP_ADDRESS_2_IDX = 16'hFFB6;
	localparam logic [15:0] TRAP_CONTROL_IDX = 16'hFFB9;
	localparam logic [15:0] TRAP_STATUS_IDX = 16'hFFBA;
	localparam logic [15:0] TRAP_MASK_IDX = 16'hFFBB;
	localparam int unsigned REGS_PER_CHANNEL = 3;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 17;

	// ---------------------------------------------------------------
	// Field layout and reset values.
	// ---------------------------------------------------------------
	localparam int unsigned ADDR_WIDTH = 24;
	localparam int unsigned BYTE_WIDTH = 8;
	localparam logic [23:0] TRAP_ADDRESS_RESET = 24'hF00000;
	localparam logic [7:0] CONTROL_RESERVED_ONES = 8'hF8;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam int unsigned HIGH_BYTE_SEL = 0;
	localparam int unsigned MID_BYTE_SEL = 1;
	localparam int unsigned LOW_BYTE_SEL = 2;

	// ---------------------------------------------------------------
	// Timing.
	// ---------------------------------------------------------------
	localparam int unsigned TRAP_DELAY_STATES = 2;

	typedef enum logic [1:0] {
		IATRAP_IDLE = 2'b00,
		IATRAP_COUNT = 2'b01,
		IATRAP_RAISED = 2'b11
	} iatrap_state_t;

endpackage : iatrap_pkg
